// ### rtl/rpd_pkg.sv
// Purpose: shared constants and types for the panel input and dimmer block
// Assumes: 250 MHz system clock, pixel clock sampled as an ordinary input
// Notes:   one place for the shared offsets, counts and pin reset levels
package rpd_pkg;
  localparam int COLOR_BITS       = 6;
  localparam int PIXEL_BITS       = 3 * COLOR_BITS;
  localparam int RED_LSB          = 2 * COLOR_BITS;
  localparam int GREEN_LSB        = COLOR_BITS;
  localparam int BLUE_LSB         = 0;
  localparam int DEFAULT_H_START  = 104;
  localparam int V_START_LINE     = 34;
  localparam int H_COUNT_BITS     = 11;
  localparam int V_COUNT_BITS     = 10;
  localparam int SYNC_STAGES      = 3;
  localparam int SYS_CLK_MHZ      = 250;
  localparam int FAULT_FILTER_NS  = 40;
  localparam int FAULT_FILTER_CYC =
    ((FAULT_FILTER_NS * SYS_CLK_MHZ + 999) / 1000 < 1) ? 1 :
    (FAULT_FILTER_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [PIXEL_BITS-1:0] PIXEL_RESET = 18'h0_0000;
  // synchronised pins, msb first: pixel clock, hsync, vsync, strobe, led open, rgb,
  // dimmer, h select, v select, strap a, strap high, strap b
  localparam int SYNC_PINS = 11 + PIXEL_BITS;
  // idle level of each pin after reset, so no false edge or strap error follows reset
  localparam logic [SYNC_PINS-1:0] PIN_IDLE = 29'h0C00_000A;

  typedef enum logic [1:0] {
    RPD_H_BLANK,
    RPD_H_ACTIVE,
    RPD_H_DONE
  } rpd_hstate_type;
endpackage : rpd_pkg

// ### rtl/rpd_buf_if.sv
// Purpose: valid/ready carrier between the sampler and the two-entry buffer
// Assumes: single clock domain
// Notes:   source drives data and valid, sink drives ready
`timescale 1ns/1ps
interface rpd_buf_if #(parameter int WIDTH = 32);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport source (output data, output valid, input ready);
  modport sink   (input data, input valid, output ready);
endinterface : rpd_buf_if

// ### rtl/rpd_skid_buf.sv
// Purpose: two-entry buffer, registered output
// Assumes: rst_n synchronous, active low
// Notes:   in_ready falls only when both entries hold a word
`timescale 1ns/1ps
module rpd_skid_buf #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  rpd_buf_if.sink               in_side,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] spare;
  logic             spare_full;
  wire              take = in_side.valid && in_side.ready;
  wire              give = out_valid && out_ready;

  initial begin
    if (WIDTH < 1) $error("width must be positive");
  end

  assign in_side.ready = !spare_full;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_valid  <= 1'b0;
      spare_full <= 1'b0;
      out_data   <= '0;
      spare      <= '0;
    end else begin
      if (!out_valid || give) begin
        out_valid  <= spare_full || take;
        out_data   <= spare_full ? spare : in_side.data;
        spare_full <= spare_full && take;
        if (spare_full && take) spare <= in_side.data;
      end else if (take) begin
        spare_full <= 1'b1;
        spare      <= in_side.data;
      end
    end
  end
endmodule : rpd_skid_buf

// ### rtl/rpd_panel_input.sv
// Purpose: pixel input sampler, display placement and backlight dimmer
// Assumes: all pins asynchronous to clk; pixel clock well below clk/4
// Notes:   sample taken on the sampled rising pixel clock edge
//
// Summary of operation
// - every colour bit is captured on a rising edge of the received pixel clock.
// - pixel data is 18 parallel bits per clock, six each for red, green and blue.
// - the visible line starts at the rising edge of the data-enable strobe.
// - with the strobe held low the line is placed by a built-in default start.
// - that default start is clock 104 after horizontal sync.
// - vertical display begins at the 34th line of the frame, always.
// - horizontal select low scans left to right, high scans mirrored.
// - vertical select high scans top to bottom, low scans flipped.
// - the backlight is lit while the dimming input is high, dark while low.
// - the fault output is high normally and low on an open LED string.
`timescale 1ns/1ps
module rpd_panel_input
  import rpd_pkg::*;
#(
  parameter int H_ACTIVE = 640,
  parameter int V_ACTIVE = 480
) (
  // system
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // video link
  input  wire logic                    pixel_sample_clock,
  input  wire logic                    hsync_n,
  input  wire logic                    vsync_n,
  input  wire logic                    active_pixel_strobe,
  input  wire logic [COLOR_BITS-1:0]   red_intensity_bits,
  input  wire logic [COLOR_BITS-1:0]   green_intensity_bits,
  input  wire logic [COLOR_BITS-1:0]   blue_intensity_bits,
  // static selects and ties
  input  wire logic                    h_reverse,
  input  wire logic                    v_normal,
  input  wire logic                    factory_tie_low_a,
  input  wire logic                    factory_tie_high,
  input  wire logic                    factory_tie_low_b,
  // pixel stream out
  output logic [PIXEL_BITS-1:0]        pixel_data,
  output logic [H_COUNT_BITS-1:0]      pixel_column,
  output logic [V_COUNT_BITS-1:0]      pixel_row,
  output logic                         pixel_valid,
  input  wire logic                    pixel_ready,
  output logic                         tie_error,
  // backlight
  input  wire logic                    dimmer_pwm,
  input  wire logic                    led_string_open,
  output logic                         backlight_on,
  output logic                         backlight_open_fault
);
  localparam int WORD = PIXEL_BITS + H_COUNT_BITS + V_COUNT_BITS;

  initial begin
    if (H_ACTIVE < 1 || H_ACTIVE >= 2**H_COUNT_BITS - DEFAULT_H_START)
      $error("H_ACTIVE out of range");
    if (V_ACTIVE < 1 || V_ACTIVE >= 2**V_COUNT_BITS - V_START_LINE)
      $error("V_ACTIVE out of range");
  end

  // ********************************************************
  // pin synchronisers
  // ********************************************************
  localparam int NPIN = SYNC_PINS;
  // static selects and straps are pins too, so they pass the same chain
  wire  [NPIN-1:0] pin_raw = {pixel_sample_clock, hsync_n, vsync_n, active_pixel_strobe,
                              led_string_open, red_intensity_bits, green_intensity_bits,
                              blue_intensity_bits, dimmer_pwm, h_reverse, v_normal,
                              factory_tie_low_a, factory_tie_high, factory_tie_low_b};
  logic [NPIN-1:0] s1, s2, s3, stable;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      // a change counts only once stages two and three agree
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          s1[gi]     <= PIN_IDLE[gi];
          s2[gi]     <= PIN_IDLE[gi];
          s3[gi]     <= PIN_IDLE[gi];
          stable[gi] <= PIN_IDLE[gi];
        end else begin
          s1[gi] <= pin_raw[gi];
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
          if (s2[gi] == s3[gi]) stable[gi] <= s3[gi];
        end
      end
    end
  endgenerate

  wire                  pck     = stable[NPIN-1];
  wire                  hs_n    = stable[NPIN-2];
  wire                  vs_n    = stable[NPIN-3];
  wire                  de      = stable[NPIN-4];
  wire                  led_opn = stable[NPIN-5];
  wire [PIXEL_BITS-1:0] rgb     = stable[PIXEL_BITS+5:6];
  wire                  pwm     = stable[5];
  wire                  hrev    = stable[4];
  wire                  vnorm   = stable[3];
  wire                  strap_a = stable[2];
  wire                  strap_h = stable[1];
  wire                  strap_b = stable[0];

  // ********************************************************
  // pixel clock edge and timing counters
  // ********************************************************
  logic                    pck_d, hs_d, vs_d, de_d;
  logic [H_COUNT_BITS-1:0] hcnt, col;
  logic [V_COUNT_BITS-1:0] vcnt;
  rpd_hstate_type          hstate;
  logic                    de_used;

  wire pck_rise   = pck && !pck_d;
  wire hs_start   = !hs_n && hs_d;
  wire vs_start   = !vs_n && vs_d;
  wire de_rise    = de && !de_d;
  // once the strobe has been seen high in the frame, its rising edge replaces the built-in start
  wire dflt_start = !de_used && hcnt == H_COUNT_BITS'(DEFAULT_H_START - 1);
  wire line_start = de_used ? de_rise : dflt_start;
  wire v_visible  = vcnt >= V_COUNT_BITS'(V_START_LINE) &&
                    vcnt <  V_COUNT_BITS'(V_START_LINE + V_ACTIVE);
  wire [V_COUNT_BITS-1:0] row_raw = vcnt - V_COUNT_BITS'(V_START_LINE);
  wire [V_COUNT_BITS-1:0] row_out = vnorm ? row_raw
                                    : V_COUNT_BITS'(V_ACTIVE - 1) - row_raw;
  wire take_pixel = pck_rise && v_visible &&
                    (hstate == RPD_H_ACTIVE || (hstate == RPD_H_BLANK && line_start));
  wire [H_COUNT_BITS-1:0] col_now = (hstate == RPD_H_BLANK) ? '0 : col;
  wire [H_COUNT_BITS-1:0] col_sel = hrev ? H_COUNT_BITS'(H_ACTIVE - 1) - col_now
                                    : col_now;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pck_d <= 1'b0;
      hs_d  <= 1'b1;
      vs_d  <= 1'b1;
      de_d  <= 1'b0;
    end else if (pck_rise) begin
      hs_d <= hs_n;
      vs_d <= vs_n;
      de_d <= de;
      pck_d <= pck;
    end else begin
      pck_d <= pck;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hcnt    <= '0;
      vcnt    <= '0;
      col     <= '0;
      hstate  <= RPD_H_BLANK;
      de_used <= 1'b0;
    end else if (pck_rise) begin
      hcnt <= hs_start ? '0 : hcnt + 1'b1;
      if (vs_start) vcnt <= '0;
      else if (hs_start) vcnt <= vcnt + 1'b1;
      if (de) de_used <= 1'b1;
      if (vs_start) de_used <= de;
      case (hstate)
        RPD_H_BLANK: begin
          if (line_start) begin
            hstate <= RPD_H_ACTIVE;
            col    <= H_COUNT_BITS'(1);
          end
        end
        RPD_H_ACTIVE: begin
          if (col == H_COUNT_BITS'(H_ACTIVE - 1)) hstate <= RPD_H_DONE;
          col <= col + 1'b1;
        end
        RPD_H_DONE: begin
          if (hs_start) hstate <= RPD_H_BLANK;
        end
        default: hstate <= RPD_H_BLANK;
      endcase
      if (hs_start) hstate <= RPD_H_BLANK;
    end
  end

  // ********************************************************
  // two-entry buffer toward the consumer
  // ********************************************************
  rpd_buf_if #(.WIDTH(WORD)) buf_in ();
  logic [WORD-1:0] buf_out;
  logic            buf_valid;

  // red high, blue low; bit 0 of each group is its lsb
  assign buf_in.data  = {rgb[RED_LSB +: COLOR_BITS], rgb[GREEN_LSB +: COLOR_BITS],
                         rgb[BLUE_LSB +: COLOR_BITS], col_sel, row_out};
  assign buf_in.valid = take_pixel;

  rpd_skid_buf #(.WIDTH(WORD)) u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_side   (buf_in),
    .out_data  (buf_out),
    .out_valid (buf_valid),
    .out_ready (pixel_ready)
  );

  assign pixel_data   = buf_out[WORD-1 -: PIXEL_BITS];
  assign pixel_column = buf_out[V_COUNT_BITS +: H_COUNT_BITS];
  assign pixel_row    = buf_out[V_COUNT_BITS-1:0];
  assign pixel_valid  = buf_valid;

  // ********************************************************
  // backlight and fault
  // ********************************************************
  localparam int OPEN_W = $clog2(FAULT_FILTER_CYC + 1);
  logic [OPEN_W-1:0] open_cnt;
  wire open_full = open_cnt == OPEN_W'(FAULT_FILTER_CYC);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      backlight_on         <= 1'b0;
      backlight_open_fault <= 1'b1;
      open_cnt             <= '0;
      tie_error            <= 1'b0;
    end else begin
      backlight_on <= pwm;
      if (!led_opn) open_cnt <= '0;
      else if (!open_full) open_cnt <= open_cnt + 1'b1;
      backlight_open_fault <= !open_full;
      // static straps are flagged, not acted on
      tie_error <= strap_a || !strap_h || strap_b;
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  property p_take_on_edge;
    @(posedge clk) disable iff (!rst_n) take_pixel |-> pck_rise && v_visible;
  endproperty
  a_take_on_edge: assert property (p_take_on_edge) else $error("pixel off edge");

  property p_default_start;
    @(posedge clk) disable iff (!rst_n)
      pck_rise && hstate == RPD_H_BLANK && !de_used && hcnt == H_COUNT_BITS'(103)
      |=> hstate == RPD_H_ACTIVE;
  endproperty
  a_default_start: assert property (p_default_start) else $error("no default start");

  property p_de_start;
    @(posedge clk) disable iff (!rst_n)
      pck_rise && hstate == RPD_H_BLANK && de_used && !de_rise |=> hstate != RPD_H_ACTIVE;
  endproperty
  a_de_start: assert property (p_de_start) else $error("start without strobe");

  property p_vstart;
    @(posedge clk) disable iff (!rst_n) take_pixel |-> vcnt >= V_COUNT_BITS'(V_START_LINE);
  endproperty
  a_vstart: assert property (p_vstart) else $error("row before start line");

  property p_hmirror;
    @(posedge clk) disable iff (!rst_n)
      take_pixel && hstate == RPD_H_BLANK |->
      col_sel == (hrev ? H_COUNT_BITS'(H_ACTIVE - 1) : 11'h000);
  endproperty
  a_hmirror: assert property (p_hmirror) else $error("bad column direction");

  property p_vflip;
    @(posedge clk) disable iff (!rst_n)
      take_pixel && vcnt == V_COUNT_BITS'(V_START_LINE) |->
      row_out == (vnorm ? 10'h000 : V_COUNT_BITS'(V_ACTIVE - 1));
  endproperty
  a_vflip: assert property (p_vflip) else $error("bad row direction");

  property p_backlight;
    @(posedge clk) disable iff (!rst_n) ##1 backlight_on == $past(pwm);
  endproperty
  a_backlight: assert property (p_backlight) else $error("backlight lag");

  sequence s_open_held;
    led_opn [*8];
  endsequence
  property p_fault;
    @(posedge clk) disable iff (!rst_n)
      s_open_held ##1 led_opn ##1 led_opn |=> ##1 !backlight_open_fault;
  endproperty
  a_fault: assert property (p_fault) else $error("open fault not shown");

  property p_packing;
    @(posedge clk) disable iff (!rst_n)
      take_pixel |-> buf_in.data[WORD-1 -: COLOR_BITS] == rgb[PIXEL_BITS-1 -: COLOR_BITS];
  endproperty
  a_packing: assert property (p_packing) else $error("colour order");
endmodule : rpd_panel_input

// ### verif/rpd_ctrl_model.sv
// Purpose: behavioural display controller that drives the video link pins
// Assumes: 160 ns pixel clock; pins change only while that clock is low
// Notes:   the pixel clock stands low between frames
`timescale 1ns/1ps
module rpd_ctrl_model
  import rpd_pkg::*;
(
  // video link
  output logic                  pixel_sample_clock,
  output logic                  hsync_n,
  output logic                  vsync_n,
  output logic                  active_pixel_strobe,
  output logic [COLOR_BITS-1:0] red_intensity_bits,
  output logic [COLOR_BITS-1:0] green_intensity_bits,
  output logic [COLOR_BITS-1:0] blue_intensity_bits
);
  // every pin is driven from time zero, none is left floating
  initial begin
    pixel_sample_clock   = 1'h0;
    hsync_n              = 1'h1;
    vsync_n              = 1'h1;
    active_pixel_strobe  = 1'h0;
    red_intensity_bits   = 6'h00;
    green_intensity_bits = 6'h00;
    blue_intensity_bits  = 6'h00;
  end

  // line on red, index on green, inverse index on blue, lsb at bit 0
  task automatic tick(input logic hs, input logic vs, input logic de, input int ln, input int ix);
    hsync_n              = hs;
    vsync_n              = vs;
    active_pixel_strobe  = de;
    red_intensity_bits   = ln[5:0];
    green_intensity_bits = ix[5:0];
    blue_intensity_bits  = ~ix[5:0];
    #80 pixel_sample_clock = 1'h1;
    #80 pixel_sample_clock = 1'h0;
  endtask

  // lines before the visible rows stay short so a default-placed frame stays quick
  task automatic frame(input logic use_de, input int de_at, input int h_act, input int v_act);
    int len;
    for (int i = 0; i < 4; i++) tick(1'h1, i > 1, 1'h0, 0, i);
    for (int ln = 1; ln < V_START_LINE + v_act; ln++) begin
      len = (use_de || ln < V_START_LINE) ? 12 : DEFAULT_H_START + h_act + 4;
      // strobe pulses once per line or stays low, never stuck high
      for (int ix = 0; ix < len; ix++)
        tick(ix > 1, 1'h1, use_de && ix >= de_at && ix < de_at + h_act, ln, ix);
    end
    for (int i = 0; i < 4; i++) tick(1'h1, 1'h1, 1'h0, 0, i);
    // released red and green lines must not keep showing the last pixel
    red_intensity_bits   = ~red_intensity_bits;
    green_intensity_bits = ~green_intensity_bits;
  endtask
endmodule // rpd_ctrl_model

// ### verif/rpd_panel_input_test.sv
// Purpose: self-checking bench for the panel input and dimmer block
// Assumes: 250 MHz clk, pixel clock from the controller model
// Notes:   small active window keeps the run short
`timescale 1ns/1ps
module rpd_panel_input_test;
  import rpd_pkg::*;
  localparam int H_ACT = 4;
  localparam int V_ACT = 2;
  localparam int WW    = V_COUNT_BITS + H_COUNT_BITS + PIXEL_BITS;

  logic                    clk = 1'h0;
  logic                    rst_n = 1'h0;
  logic                    pclk, hs_n, vs_n, de;
  logic [COLOR_BITS-1:0]   red, green, blue;
  logic                    h_reverse = 1'h0;
  logic                    v_normal = 1'h1;
  logic                    tie_a = 1'h0;
  logic                    tie_h = 1'h1;
  logic                    tie_b = 1'h0;
  logic [PIXEL_BITS-1:0]   pixel_data;
  logic [H_COUNT_BITS-1:0] pixel_column;
  logic [V_COUNT_BITS-1:0] pixel_row;
  logic                    pixel_valid, tie_error, backlight_on, backlight_open_fault;
  logic                    pixel_ready = 1'h1;
  logic                    dimmer_pwm = 1'h0; // idle backlight input held low
  logic                    led_string_open = 1'h0;
  logic                    stall_on = 1'h0;
  logic                    hold_pend = 1'h0;
  logic [PIXEL_BITS-1:0]   held;
  logic [WW-1:0]           rx_q[$];
  int                      cyc = 0;
  int                      failures = 0;
  int                      num_checks = 0;

  rpd_panel_input #(.H_ACTIVE(H_ACT), .V_ACTIVE(V_ACT)) u_rpd_panel_input (
    .clk(clk), .rst_n(rst_n), .pixel_sample_clock(pclk), .hsync_n(hs_n), .vsync_n(vs_n),
    .active_pixel_strobe(de), .red_intensity_bits(red), .green_intensity_bits(green),
    .blue_intensity_bits(blue), .h_reverse(h_reverse), .v_normal(v_normal),
    .factory_tie_low_a(tie_a), .factory_tie_high(tie_h), .factory_tie_low_b(tie_b),
    .pixel_data(pixel_data), .pixel_column(pixel_column), .pixel_row(pixel_row),
    .pixel_valid(pixel_valid), .pixel_ready(pixel_ready), .tie_error(tie_error),
    .dimmer_pwm(dimmer_pwm), .led_string_open(led_string_open),
    .backlight_on(backlight_on), .backlight_open_fault(backlight_open_fault));

  rpd_ctrl_model u_rpd_ctrl_model (
    .pixel_sample_clock(pclk), .hsync_n(hs_n), .vsync_n(vs_n), .active_pixel_strobe(de),
    .red_intensity_bits(red), .green_intensity_bits(green), .blue_intensity_bits(blue));

  // ****************************************
  // helpers
  // ****************************************
  initial begin
    forever #2 clk = ~clk;
  end

  task automatic conclude;
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // bounded wait on a status output: 0 strap error, 1 backlight, 2 fault
  task automatic await(input int sel, input logic val);
    logic got;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      got = sel == 0 ? tie_error : sel == 1 ? backlight_on : backlight_open_fault;
      if (got === val) break;
    end
    check(got, val);
  endtask

  task automatic check_frame(input int de_at, input logic hr, input logic vn);
    logic [5:0]              ix;
    logic [V_COUNT_BITS-1:0] row;
    logic [H_COUNT_BITS-1:0] col;
    check(rx_q.size(), H_ACT * V_ACT);
    for (int k = 0; k < rx_q.size(); k++) begin
      ix  = 6'(de_at + k % H_ACT);
      col = H_COUNT_BITS'(hr ? H_ACT - 1 - k % H_ACT : k % H_ACT);
      row = V_COUNT_BITS'(vn ? k / H_ACT : V_ACT - 1 - k / H_ACT);
      check(rx_q[k], {row, col, 6'(V_START_LINE + k / H_ACT), ix, ~ix});
    end
    rx_q.delete();
  endtask

  // consumer: a stall pattern keeps at most two pixels waiting, so none may be lost
  always @(negedge clk) begin
    cyc <= cyc + 1;
    pixel_ready <= !stall_on || cyc % 100 >= 70;
  end

  always @(posedge clk) begin
    if (hold_pend) check({pixel_valid, pixel_data}, {1'h1, held});
    hold_pend <= pixel_valid === 1'h1 && pixel_ready === 1'h0;
    held <= pixel_data;
    if (pixel_valid === 1'h1 && pixel_ready === 1'h1)
      rx_q.push_back({pixel_row, pixel_column, pixel_data});
  end

  initial begin
    #300000;
    failures++;
    conclude();
  end

  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    @(negedge clk);
    check({pixel_valid, backlight_on, backlight_open_fault, tie_error}, 4'h2);
    for (int s = 0; s < 3; s++) begin
      {tie_a, tie_h, tie_b} = 3'h2 ^ (3'h4 >> s);
      await(0, 1'h1);
      {tie_a, tie_h, tie_b} = 3'h2;
      await(0, 1'h0);
    end
    dimmer_pwm = 1'h1; // supply assumed present before the first pulse
    await(1, 1'h1);
    dimmer_pwm = 1'h0; // waveform stopped before supply removal
    await(1, 1'h0);
    led_string_open = 1'h1;
    repeat (4) @(negedge clk);
    led_string_open = 1'h0;
    repeat (20) @(negedge clk) check(backlight_open_fault, 1'h1);
    led_string_open = 1'h1;
    await(2, 1'h0);
    led_string_open = 1'h0;
    await(2, 1'h1);
    u_rpd_ctrl_model.frame(1'h1, 3, H_ACT, V_ACT);
    repeat (200) @(negedge clk);
    check_frame(3, 1'h0, 1'h1);
    h_reverse = 1'h1;
    v_normal  = 1'h0;
    stall_on  = 1'h1;
    u_rpd_ctrl_model.frame(1'h1, 5, H_ACT, V_ACT);
    repeat (200) @(negedge clk);
    check_frame(5, 1'h1, 1'h0);
    h_reverse = 1'h0;
    v_normal  = 1'h1;
    stall_on  = 1'h0;
    u_rpd_ctrl_model.frame(1'h0, 0, H_ACT, V_ACT);
    repeat (200) @(negedge clk);
    check_frame(DEFAULT_H_START, 1'h0, 1'h1);
    conclude();
  end
endmodule // rpd_panel_input_test
